// ### sim/cpu_model.sv
// Purpose: CPU core clock consumer model.
// Assumes: Clock enables are sampled on the ref_clk rising edge.
// Notes:   Counts executed cycles; issues power-save on command.
`timescale 1ns/1ps
module cpu_model (
  // Clock
  input  wire logic        ref_clk,
  // Bench control
  input  wire logic        run_idle,
  input  wire logic        clr,
  // Device side
  input  wire logic        cpu_clk_en,
  output logic             idle_request,
  output logic [15:0]      instr_count
);
  // ----------------------------------------------------------
  // Instruction issue
  // ----------------------------------------------------------
  // A halted core cannot issue the power-save instruction
  assign idle_request = run_idle & cpu_clk_en;

  // Executed cycles; a stuck enable shows as a wrong count
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      instr_count <= 16'h0000;
    end else if (cpu_clk_en) begin
      instr_count <= instr_count + 16'h0001;
    end
  end
endmodule

// ### sim/testbench.sv
// Purpose: Self-checking bench for the clock and power-save block.
// Assumes: Register port answers reads one cycle after the strobe.
// Notes:   Slowdown is measured over 128-cycle windows.
`timescale 1ns/1ps
`include "clk_pwr_regs.svh"
module testbench;
  // Clock, resets and register port
  logic        ref_clk, rst, por_rst, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd, instr_count, k, ticks;
  // CPU, watchdog and pins
  logic        irq_pending, wdt_timeout, wdt_enabled, fail_monitor_enabled;
  logic        pll_lock_pin, run_idle, clr, idle_request, cpu_clk_en;
  logic        cpu_halted, cpu_resume, resume_to_isr, wdt_clear, seen;
  logic        low_power_rc_run, sys_clk_run, aux_pll_run;
  logic        aux_clk_tick, pll_out_pin, pri_osc_pin;
  logic [7:0]  periph_clk_run;
  logic [1:0]  aux_pll_ref;
  int          bad_count, checks, cycles;

  aux_clock_and_power_save_control i_dut (.ref_clk(ref_clk), .rst(rst),
    .por_rst(por_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .idle_request(idle_request), .irq_pending(irq_pending),
    .cpu_clk_en(cpu_clk_en), .cpu_halted(cpu_halted), .cpu_resume(cpu_resume),
    .resume_to_isr(resume_to_isr), .wdt_timeout(wdt_timeout),
    .wdt_enabled(wdt_enabled), .fail_monitor_enabled(fail_monitor_enabled),
    .wdt_clear(wdt_clear), .low_power_rc_run(low_power_rc_run),
    .sys_clk_run(sys_clk_run), .periph_clk_run(periph_clk_run),
    .pll_lock_pin(pll_lock_pin), .pll_out_pin(pll_out_pin), .pri_osc_pin(pri_osc_pin),
    .aux_pll_run(aux_pll_run), .aux_pll_ref(aux_pll_ref), .aux_clk_tick(aux_clk_tick));

  cpu_model i_cpu (.ref_clk(ref_clk), .run_idle(run_idle), .clr(clr),
    .cpu_clk_en(cpu_clk_en), .idle_request(idle_request),
    .instr_count(instr_count));

  // ----------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Whole run is about 3100 cycles; ten thousand means a hang
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      bad_count++;
      finish_test();
    end
  end
  // Free-running oscillator pins: primary every 2 cycles, PLL every 4
  always @(posedge ref_clk) begin
    {pll_out_pin, pri_osc_pin} <= {pll_out_pin ^ pri_osc_pin, ~pri_osc_pin};
  end
  // Divided auxiliary ticks, cleared together with the cycle count
  always @(posedge ref_clk) begin
    ticks <= clr ? 16'h0000 : ticks + 16'(aux_clk_tick);
  end

  // ----------------------------------------------------------
  // Bus, compare and measurement tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  task automatic count128();
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (128) @(posedge ref_clk);
    #1;
    k = instr_count;
  endtask
  // First window only settles the divider after its restart
  task automatic aux_ticks(input logic [15:0] v, input logic [31:0] e);
    wr(`OFS_AUX_CTRL, v);
    count128();
    count128();
    chk(ticks, e);
  endtask
  task automatic pulse_rst(input logic por);
    @(posedge ref_clk);
    if (por) por_rst <= 1'b1;
    else rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    por_rst <= 1'b0;
    rst     <= 1'b0;
  endtask
  // Idle entry then wake; early cause lands during the entry cycle
  task automatic idle_wake(input logic by_irq, input logic early);
    @(posedge ref_clk);
    run_idle <= 1'b1;
    @(posedge ref_clk);
    run_idle    <= 1'b0;
    irq_pending <= early;
    #1;
    chk(wdt_clear, 1'b1);
    chk({cpu_halted, cpu_clk_en}, 2'b10);
    seen = 1'b0;
    if (!early) begin
      @(posedge ref_clk);
      #1;
      chk({wdt_clear, sys_clk_run, periph_clk_run}, 10'h1FF);
      @(posedge ref_clk);
      irq_pending <= by_irq;
      wdt_timeout <= !by_irq;
    end
    @(posedge ref_clk);
    irq_pending <= 1'b0;
    wdt_timeout <= 1'b0;
    if (!early) begin
      repeat (3) @(posedge ref_clk);
      #1;
      chk({cpu_resume, resume_to_isr, cpu_halted}, {1'b1, by_irq, 1'b0});
    end else begin
      for (int i = 0; i < 8 && !seen; i++) begin
        @(posedge ref_clk);
        #1;
        seen = cpu_resume;
      end
      chk(seen, 1'b1);
    end
    @(posedge ref_clk);
    #1;
    chk({cpu_clk_en, cpu_halted, cpu_resume}, 3'b100);
  endtask
  task finish_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    {rst, por_rst} = 2'b11;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {irq_pending, wdt_timeout, wdt_enabled, fail_monitor_enabled} = '0;
    {pll_lock_pin, run_idle, clr, pll_out_pin, pri_osc_pin} = '0;
    repeat (10) @(posedge ref_clk);
    {rst, por_rst} <= 2'b00;
    // Auxiliary register, lock and reference routing
    rdr(`OFS_AUX_CTRL);
    chk(rd, 16'h2700);
    wr(`OFS_AUX_CTRL, 16'hFFFF);
    rdr(`OFS_AUX_CTRL);
    chk(rd, 16'hA7C0);
    pll_lock_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdr(`OFS_AUX_CTRL);
    chk({rd, aux_pll_run}, {16'hE7C0, 1'b1});
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_AUX_CTRL, 16'(i << 6));
      @(posedge ref_clk);
      #1;
      chk(aux_pll_ref, i[0] ? 2'b10 : 2'(i >> 1));
    end
    rdr(`OFS_AUX_CTRL);
    chk({rd, aux_pll_run}, {16'h00C0, 1'b0});
    pulse_rst(1'b0);
    rdr(`OFS_AUX_CTRL);
    chk(rd, 16'h00C0);
    pulse_rst(1'b1);
    rdr(`OFS_AUX_CTRL);
    chk(rd, 16'h2700);
    aux_ticks(16'h2780, 32'd64);
    aux_ticks(16'h2580, 32'd16);
    aux_ticks(16'h2280, 32'd2);
    aux_ticks(16'h2700, 32'd0);
    aux_ticks(16'h8780, 32'd32);
    aux_ticks(16'h0780, 32'd0);
    $display("test aux done");
    // Idle entry and the three wake paths
    idle_wake(1'b1, 1'b0);
    idle_wake(1'b0, 1'b0);
    idle_wake(1'b1, 1'b1);
    $display("test idle done");
    // Slowdown ratios, enable bit, restore on interrupt
    for (int n = 0; n < 8; n++) begin
      wr(`OFS_CLK_DIVISOR, 16'h0800 | 16'(n << 12));
      count128();
      chk(k, 16'(128 >> n));
    end
    wr(`OFS_CLK_DIVISOR, 16'h7000);
    count128();
    chk(k, 16'd128);
    wr(`OFS_CLK_DIVISOR, 16'h7800);
    irq_pending <= 1'b1;
    count128();
    chk(k, 16'd1);
    irq_pending <= 1'b0;
    wr(`OFS_CLK_DIVISOR, 16'hF800);
    irq_pending <= 1'b1;
    @(posedge ref_clk);
    irq_pending <= 1'b0;
    count128();
    chk(k, 16'd128);
    rdr(`OFS_PWR_STATUS);
    chk(rd[1], 1'b0);
    $display("test slowdown done");
    // Module gating and low-power oscillator
    wr(`OFS_MODULE_GATE, 16'h0005);
    @(posedge ref_clk);
    #1;
    chk(periph_clk_run, 8'hFA);
    wr(`OFS_MODULE_GATE, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk(periph_clk_run, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      {wdt_enabled, fail_monitor_enabled} <= 2'(i);
      repeat (3) @(posedge ref_clk);
      #1;
      chk(low_power_rc_run, i != 0);
    end
    $display("test gate done");
    finish_test();
  end
endmodule

// ### src/aux_clock_and_power_save_control.sv
// Purpose: Auxiliary clock control, idle sequencing, CPU slowdown and
//          per-module clock gating for a small microcontroller.
// Assumes: por_rst and rst are synchronous, active high; clocks leave as
//          enables on ref_clk; oscillator pins are asynchronous.
// Notes:   Register port answers reads one cycle later, never waits.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "clk_pwr_regs.svh"
module aux_clock_and_power_save_control
  import clk_pwr_pkg::*;
#(
  parameter int NUM_MODULES = 8
) (
  // Clock and resets
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    por_rst,
  // Register port
  input  wire logic [3:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [15:0]             reg_rdata,
  // CPU side
  input  wire logic                    idle_request,
  input  wire logic                    irq_pending,
  output logic                         cpu_clk_en,
  output logic                         cpu_halted,
  output logic                         cpu_resume,
  output logic                         resume_to_isr,
  // Watchdog and monitor
  input  wire logic                    wdt_timeout,
  input  wire logic                    wdt_enabled,
  input  wire logic                    fail_monitor_enabled,
  output logic                         wdt_clear,
  output logic                         low_power_rc_run,
  // System and peripheral clocks
  output logic                         sys_clk_run,
  output logic      [NUM_MODULES-1:0]  periph_clk_run,
  // Auxiliary PLL and oscillators
  input  wire logic                    pll_lock_pin,
  input  wire logic                    pll_out_pin,
  input  wire logic                    pri_osc_pin,
  output logic                         aux_pll_run,
  output logic      [1:0]              aux_pll_ref,
  output logic                         aux_clk_tick
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [15:0]            aux_clock_control;
  logic [15:0]            clock_divisor_register;
  logic [NUM_MODULES-1:0] module_clock_gate;
  idle_state_t            state;
  idle_state_t            next_state;
  logic [2:0]             resume_cnt;
  logic                   wake_held;
  logic                   woke_by_irq;
  logic                   lock_s1, lock_s2;
  logic                   pll_s1, pll_s2, pll_s3;
  logic                   osc_s1, osc_s2, osc_s3;
  logic                   aux_lock_status;
  logic                   slow_active;
  logic                   slow_restart;
  logic                   slow_tick;
  logic                   roi_clear;
  logic                   aux_src_edge;
  logic                   aux_tick_raw;
  logic [2:0]             aux_shift;
  logic [2:0]             slow_shift;
  logic                   wr_aux, wr_cdiv, wr_gate;

  assign wr_aux  = reg_wr && (reg_addr == `OFS_AUX_CTRL);
  assign wr_cdiv = reg_wr && (reg_addr == `OFS_CLK_DIVISOR);
  assign wr_gate = reg_wr && (reg_addr == `OFS_MODULE_GATE);

  // Auxiliary register ignores ordinary resets on purpose
  always_ff @(posedge ref_clk) begin
    if (por_rst) begin
      aux_clock_control <= `AUX_CTRL_RESET;
    end else if (wr_aux) begin
      aux_clock_control <= reg_wdata & `AUX_CTRL_WMASK;
    end
  end

  // Clock divisor; interrupt may drop slowdown when asked to
  always_ff @(posedge ref_clk) begin
    if (rst || por_rst) begin
      clock_divisor_register <= `CDIV_RESET;
    end else if (wr_cdiv) begin
      clock_divisor_register <= reg_wdata & `CDIV_WMASK;
    end else if (roi_clear) begin
      clock_divisor_register[`CDIV_SLOW_BIT] <= 1'b0;
    end
  end

  // Interrupt restores full speed only with the restore bit set
  assign roi_clear = irq_pending && clock_divisor_register[`CDIV_ROI_BIT]
                     && clock_divisor_register[`CDIV_SLOW_BIT];

  // Module gate bits, all modules run after reset
  always_ff @(posedge ref_clk) begin
    if (rst || por_rst) begin
      module_clock_gate <= '0;
    end else if (wr_gate) begin
      module_clock_gate <= reg_wdata[NUM_MODULES-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Two flops before any use; third flop only for edge detection
  always_ff @(posedge ref_clk) begin
    if (rst || por_rst) begin
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      pll_s1  <= 1'b0;
      pll_s2  <= 1'b0;
      pll_s3  <= 1'b0;
      osc_s1  <= 1'b0;
      osc_s2  <= 1'b0;
      osc_s3  <= 1'b0;
    end else begin
      lock_s1 <= pll_lock_pin;
      lock_s2 <= lock_s1;
      pll_s1  <= pll_out_pin;
      pll_s2  <= pll_s1;
      pll_s3  <= pll_s2;
      osc_s1  <= pri_osc_pin;
      osc_s2  <= osc_s1;
      osc_s3  <= osc_s2;
    end
  end

  // ----------------------------------------------------------------------
  // Auxiliary clock path
  // ----------------------------------------------------------------------
  // Lock only counts while the PLL is asked to run
  assign aux_lock_status = aux_clock_control[`AUX_PLL_EN_BIT] && lock_s2;

  // Source edge: oscillator branch is dead when no reference chosen
  always_comb begin
    if (aux_clock_control[`AUX_DIV_SRC_BIT]) begin
      aux_src_edge = aux_clock_control[`AUX_REF_SRC_BIT] && osc_s2 && !osc_s3;
    end else begin
      aux_src_edge = aux_clock_control[`AUX_PLL_EN_BIT] && pll_s2 && !pll_s3;
    end
  end

  // Code 111 is divide by one; code 000 held at divide by 64
  always_comb begin
    if (aux_clock_control[`AUX_DIV_HI:`AUX_DIV_LO] == 3'b000) begin
      aux_shift = 3'd6;
    end else begin
      aux_shift = 3'd7 - aux_clock_control[`AUX_DIV_HI:`AUX_DIV_LO];
    end
  end

  clock_ratio_divider #(
    .CNT_W (7)
  ) u_aux_div (
    .ref_clk  (ref_clk),
    .rst      (rst || por_rst),
    .restart  (wr_aux),
    .tick_in  (aux_src_edge),
    .shift    (aux_shift),
    .tick_out (aux_tick_raw)
  );

  // PLL control and reference outputs, fast RC takes priority
  always_ff @(posedge ref_clk) begin
    if (por_rst) begin
      aux_pll_run  <= 1'b0;
      aux_pll_ref  <= REF_NONE;
      aux_clk_tick <= 1'b0;
    end else begin
      aux_pll_run  <= aux_clock_control[`AUX_PLL_EN_BIT];
      aux_clk_tick <= aux_tick_raw;
      if (aux_clock_control[`AUX_FRC_SEL_BIT]) begin
        aux_pll_ref <= REF_FAST_RC;
      end else if (aux_clock_control[`AUX_REF_SRC_BIT]) begin
        aux_pll_ref <= REF_PRIMARY;
      end else begin
        aux_pll_ref <= REF_NONE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Idle sequencer
  // ----------------------------------------------------------------------
  // Run, one entry cycle, idle, then a fixed resume wait
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (idle_request) begin
          next_state = ST_ENTER;
        end
      end
      ST_ENTER: begin
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (irq_pending || wdt_timeout || wake_held) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (resume_cnt == 3'd1) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // Any reset leaves idle at once
  always_ff @(posedge ref_clk) begin
    if (rst || por_rst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Wake cause seen during entry is held until idle is reached
  always_ff @(posedge ref_clk) begin
    if (rst || por_rst) begin
      wake_held <= 1'b0;
    end else if (state == ST_ENTER && (irq_pending || wdt_timeout)) begin
      wake_held <= 1'b1;
    end else if (state == ST_WAKE) begin
      wake_held <= 1'b0;
    end
  end

  // Resume wait counter and the reason for waking
  always_ff @(posedge ref_clk) begin
    if (rst || por_rst) begin
      resume_cnt  <= 3'd0;
      woke_by_irq <= 1'b0;
    end else if (state == ST_IDLE && next_state == ST_WAKE) begin
      resume_cnt  <= `RESUME_CYCLES;
      woke_by_irq <= irq_pending || (wake_held && !wdt_timeout);
    end else if (state == ST_WAKE) begin
      resume_cnt  <= resume_cnt - 3'd1;
    end
  end

  // ----------------------------------------------------------------------
  // CPU slowdown
  // ----------------------------------------------------------------------
  assign slow_active  = clock_divisor_register[`CDIV_SLOW_BIT];
  assign slow_shift   = clock_divisor_register[`CDIV_RATIO_HI:`CDIV_RATIO_LO];
  // Restarting on any divisor write keeps CPU ticks on system edges
  assign slow_restart = wr_cdiv || !slow_active;

  clock_ratio_divider #(
    .CNT_W (7)
  ) u_slow_div (
    .ref_clk  (ref_clk),
    .rst      (rst || por_rst),
    .restart  (slow_restart),
    .tick_in  (1'b1),
    .shift    (slow_shift),
    .tick_out (slow_tick)
  );

  // CPU enable; peripherals never see the slowdown
  always_ff @(posedge ref_clk) begin
    if (rst || por_rst) begin
      cpu_clk_en <= 1'b0;
      cpu_halted <= 1'b0;
    end else begin
      cpu_halted <= (next_state != ST_RUN);
      if (next_state != ST_RUN) begin
        cpu_clk_en <= 1'b0;
      end else if (slow_active && !roi_clear) begin
        cpu_clk_en <= slow_tick;
      end else begin
        cpu_clk_en <= 1'b1;
      end
    end
  end

  // Wake pulses and watchdog clear on entry
  always_ff @(posedge ref_clk) begin
    if (rst || por_rst) begin
      cpu_resume    <= 1'b0;
      resume_to_isr <= 1'b0;
      wdt_clear     <= 1'b0;
    end else begin
      cpu_resume    <= (state == ST_WAKE) && (next_state == ST_RUN);
      resume_to_isr <= (state == ST_WAKE) && (next_state == ST_RUN) && woke_by_irq;
      wdt_clear     <= (state == ST_RUN) && (next_state == ST_ENTER);
    end
  end

  // System clock stays up; low-power RC follows its users
  always_ff @(posedge ref_clk) begin
    if (rst || por_rst) begin
      sys_clk_run      <= 1'b1;
      low_power_rc_run <= 1'b0;
    end else begin
      sys_clk_run      <= 1'b1;
      low_power_rc_run <= wdt_enabled || fail_monitor_enabled;
    end
  end

  // ----------------------------------------------------------------------
  // Peripheral clock gating
  // ----------------------------------------------------------------------
  // Register write lands, next edge changes the module clock
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MODULES; gi++) begin : g_gate
      always_ff @(posedge ref_clk) begin
        if (rst || por_rst) begin
          periph_clk_run[gi] <= 1'b1;
        end else begin
          periph_clk_run[gi] <= !module_clock_gate[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst || por_rst || !reg_rd) begin
      reg_rdata <= 16'h0000;
    end else begin
      case (reg_addr)
        `OFS_AUX_CTRL: begin
          reg_rdata <= (aux_clock_control & ~(16'h0001 << `AUX_LOCK_BIT))
                       | (16'(aux_lock_status) << `AUX_LOCK_BIT);
        end
        `OFS_CLK_DIVISOR: begin
          reg_rdata <= clock_divisor_register;
        end
        `OFS_MODULE_GATE: begin
          reg_rdata <= 16'(module_clock_gate);
        end
        `OFS_PWR_STATUS: begin
          reg_rdata <= (16'(state != ST_RUN) << `STAT_IDLE_BIT)
                       | (16'(slow_active) << `STAT_SLOW_BIT)
                       | (16'(aux_lock_status) << `STAT_LOCK_BIT);
        end
        default: begin
          reg_rdata <= 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || por_rst);

  sequence s_enter_idle;
    state == ST_RUN && idle_request ##1 state == ST_ENTER;
  endsequence

  sequence s_wake_start;
    state == ST_IDLE && (irq_pending || wdt_timeout);
  endsequence

  a_idle_halts_cpu: assert property (
    s_enter_idle |-> !cpu_clk_en && cpu_halted)
    else $error("CPU still clocked after idle entry");

  a_entry_clears_wdt: assert property (
    s_enter_idle |-> wdt_clear ##1 !wdt_clear)
    else $error("Watchdog not cleared once on idle entry");

  a_wake_resume_time: assert property (
    s_wake_start |-> ##[2:4] cpu_resume)
    else $error("Resume not within 2 to 4 cycles of wake");

  a_entry_irq_held: assert property (
    state == ST_ENTER && irq_pending |-> ##1 state == ST_IDLE ##1 state == ST_WAKE)
    else $error("Interrupt during entry did not wake device");

  a_lock_needs_enable: assert property (
    reg_rd && reg_addr == `OFS_AUX_CTRL && !aux_clock_control[`AUX_PLL_EN_BIT]
    |=> !reg_rdata[`AUX_LOCK_BIT])
    else $error("Lock read high with PLL disabled");

  a_gate_one_cycle: assert property (
    wr_gate && reg_wdata[0] |=> ##1 !periph_clk_run[0])
    else $error("Module gate not applied one cycle later");

  a_roi_restores: assert property (
    state == ST_RUN && slow_active && irq_pending
    && clock_divisor_register[`CDIV_ROI_BIT] && !wr_cdiv |=> cpu_clk_en && !slow_active)
    else $error("Interrupt did not restore full speed");

  a_slow_no_roi: assert property (
    slow_active && !clock_divisor_register[`CDIV_ROI_BIT] && !wr_cdiv
    |=> slow_active)
    else $error("Slowdown dropped without restore bit");

  a_full_ratio_1: assert property (
    state == ST_RUN && next_state == ST_RUN && !slow_active && !wr_cdiv |=> cpu_clk_en)
    else $error("CPU not at full rate outside slowdown");

  a_ref_frc_first: assert property (
    aux_clock_control[`AUX_FRC_SEL_BIT] |=> aux_pll_ref == REF_FAST_RC)
    else $error("Fast RC not chosen as PLL reference");

endmodule

// ### src/clk_pwr_pkg.sv
// Purpose: Types shared by the power-save controller.
// Assumes: Nothing beyond SystemVerilog enums.
// Notes:   Gray codes along run, enter, idle, wake.
package clk_pwr_pkg;

  // Power-save sequencer states
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_ENTER = 2'b01,
    ST_IDLE  = 2'b11,
    ST_WAKE  = 2'b10
  } idle_state_t;

  // Auxiliary PLL reference choice
  typedef enum logic [1:0] {
    REF_NONE    = 2'b00,
    REF_PRIMARY = 2'b01,
    REF_FAST_RC = 2'b10
  } pll_ref_t;

endpackage

// ### src/clk_pwr_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts
//          for the auxiliary clock and power-save controller.
// Assumes: Registers are 16 bits wide, addressed by word index.
// Notes:   Included by the controller; definitions only.
//
// Contract
// - Lock bit read-only, resets 0; source select and divider bits reset 1.
// - Divider code 111 divides by 1; each lower code doubles, up to 64.
// - Reference select 1 feeds primary oscillator; 0 selects no clock.
// - Internal RC select 1 feeds PLL from fast RC; 0 follows reference select.
// - Auxiliary register resets only on power-on reset.
// - Idle stops the CPU executing instructions.
// - Entering idle clears the watchdog counter.
// - Idle keeps system clock running; peripherals clocked unless gated.
// - Idle keeps low-power RC running when watchdog or clock-fail monitor on.
// - Idle ends on enabled interrupt, any reset, or watchdog time-out.
// - Wake-up reapplies CPU clock; execution resumes 2 to 4 cycles later.
// - Interrupt during power-save entry is held, then wakes the device.
// - Slowdown keeps system clock; peripherals full speed, CPU divided.
// - Slowdown active when clock divisor bit 11 is set.
// - Bits 14..12 pick CPU ratio 1:1 to 1:128, default 1:1.
// - Bit 15 set lets an interrupt restore full CPU speed; clear, no effect.
// - Divided CPU clock and peripheral clock stay synchronised.
// - Gating bit set stops peripheral one cycle later; clear restarts it.
`ifndef CLK_PWR_REGS_SVH
`define CLK_PWR_REGS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define OFS_AUX_CTRL     4'h0
`define OFS_CLK_DIVISOR  4'h1
`define OFS_MODULE_GATE  4'h2
`define OFS_PWR_STATUS   4'h3

// ----------------------------------------------------------------------
// Auxiliary clock control fields
// ----------------------------------------------------------------------
`define AUX_PLL_EN_BIT   15
`define AUX_LOCK_BIT     14
`define AUX_DIV_SRC_BIT  13
`define AUX_DIV_HI       10
`define AUX_DIV_LO       8
`define AUX_REF_SRC_BIT  7
`define AUX_FRC_SEL_BIT  6
`define AUX_CTRL_RESET   16'h2700
`define AUX_CTRL_WMASK   16'hA7C0

// ----------------------------------------------------------------------
// Clock divisor fields
// ----------------------------------------------------------------------
`define CDIV_ROI_BIT     15
`define CDIV_RATIO_HI    14
`define CDIV_RATIO_LO    12
`define CDIV_SLOW_BIT    11
`define CDIV_RESET       16'h0000
`define CDIV_WMASK       16'hF800

// ----------------------------------------------------------------------
// Status fields and timing
// ----------------------------------------------------------------------
`define STAT_IDLE_BIT    0
`define STAT_SLOW_BIT    1
`define STAT_LOCK_BIT    2
`define RESUME_CYCLES    3'd3

`endif

// ### src/clock_ratio_divider.sv
// Purpose: Power-of-two tick divider for clock enables.
// Assumes: tick_in is on ref_clk; shift 0 passes every tick.
// Notes:   restart realigns the count so ratios start in phase.
`timescale 1ns/1ps
module clock_ratio_divider #(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Control
  input  wire logic         restart,
  input  wire logic         tick_in,
  input  wire logic [2:0]   shift,
  // Divided tick
  output logic              tick_out
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] mask;

  // Low shift bits set form the wrap mask
  assign mask = CNT_W'((1 << shift) - 1);

  // Count input ticks; restart keeps the divided edge aligned
  always_ff @(posedge ref_clk) begin
    if (rst || restart) begin
      count <= '0;
    end else if (tick_in) begin
      count <= count + CNT_W'(1);
    end
  end

  // Emit one tick each time the masked count wraps
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && !restart && ((count & mask) == mask);
    end
  end

endmodule
